// >>> src/dual_adc_output_mux.v
// dual channel converter output multiplexer with wishbone control
// assumes synchronous inputs on clk_sys_i, sample taken each clock enable
// Notes on behaviour
// - output code is unsigned straight binary
// - float input high releases all eight output bits
// - pick low drives quadrature result while control pick bit 1 is clear
// - pick high drives in-phase result
// - low power plus stopped clock enters standby
// - strap to vref 1V, ground 2V
// - strap to supply selects external reference
// - divider tap scales on-chip reference
// - both channels sample on same edge
// - result reaches outputs five periods later
// - each channel has own output latch
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
`include "dual_adc_defines.vh"

module sample_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW = `FIFO_AW
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [WIDTH-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr;
  wire do_rd;
  assign in_ready_o = (count != DEPTH);
  assign out_valid_o = (count != 0);
  assign out_data_o = mem[rd_ptr];
  assign do_wr = in_valid_i && in_ready_o;
  assign do_rd = out_valid_o && out_ready_i;
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
      if (do_wr && !do_rd)
        count <= count + 1'b1;
      else if (do_rd && !do_wr)
        count <= count - 1'b1;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////

module dual_adc_output_mux (
  // clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // quantised channel inputs
  input wire [7:0] i_level_i,
  input wire [7:0] q_level_i,
  // pins
  input wire output_float_i,
  input wire channel_pick_i,
  input wire low_power_request_i,
  input wire [1:0] reference_sense_strap_i,
  // output bus
  output reg [7:0] output_bits_o,
  output reg [7:0] output_bits_oe_n_o,
  output reg standby_o,
  output reg [2:0] ref_mode_o
);
  reg [31:0] ctrl;
  reg [7:0] i_pipe [0:`PIPE_DEPTH-1];
  reg [7:0] q_pipe [0:`PIPE_DEPTH-1];
  reg [7:0] i_latch;
  reg [7:0] q_latch;
  reg [7:0] next_word;
  wire clk_run;
  wire float_all;
  wire pick_i;
  wire fifo_in_ready;
  wire [15:0] fifo_data;
  wire fifo_valid;
  wire fifo_pop;
  wire wb_req;
  integer k;

  function [2:0] strap_mode;
    input [1:0] strap;
    begin
      case (strap)
        `STRAP_VREF: strap_mode = `REF_1V;
        `STRAP_ANALOG_GROUND: strap_mode = `REF_2V;
        `STRAP_ANALOG_SUPPLY: strap_mode = `REF_EXT;
        default: strap_mode = `REF_PROG;
      endcase
    end
  endfunction

  assign clk_run = ctrl[`CTRL_CLKEN_BIT];
  assign float_all = output_float_i | ctrl[`CTRL_FLOAT_BIT];
  assign pick_i = channel_pick_i | ctrl[`CTRL_PICK_BIT];
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign fifo_pop = wb_req && !wb_we_i && (wb_adr_i == `ADDR_STATUS + 8'h0C);

  ////////////////////////////////////////////////////////////////////////
  // pipeline: both channels sampled on the same enabled edge
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      for (k = 0; k < `PIPE_DEPTH; k = k + 1)
      begin
        i_pipe[k] <= 8'h00;
        q_pipe[k] <= 8'h00;
      end
      i_latch <= 8'h00;
      q_latch <= 8'h00;
    end
    else if (clk_run)
    begin
      i_pipe[0] <= i_level_i;
      q_pipe[0] <= q_level_i;
      for (k = 1; k < `PIPE_DEPTH; k = k + 1)
      begin
        i_pipe[k] <= i_pipe[k-1];
        q_pipe[k] <= q_pipe[k-1];
      end
      i_latch <= i_pipe[`PIPE_DEPTH-1];
      q_latch <= q_pipe[`PIPE_DEPTH-1];
    end
  end

  sample_fifo #(
    .WIDTH(16),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_data_i({i_latch, q_latch}),
    .in_valid_i(clk_run),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  ////////////////////////////////////////////////////////////////////////
  // output multiplexer and float control
  always @*
  begin
    if (pick_i)
      next_word = i_latch;
    else
      next_word = q_latch;
  end

  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      output_bits_o <= 8'h00;
      output_bits_oe_n_o <= 8'hFF;
      standby_o <= 1'b0;
      ref_mode_o <= `REF_1V;
    end
    else
    begin
      output_bits_o <= next_word;
      output_bits_oe_n_o <= {8{float_all}};
      standby_o <= (low_power_request_i | ctrl[`CTRL_LOWPWR_BIT]) && !clk_run;
      ref_mode_o <= strap_mode(reference_sense_strap_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave, ack one cycle after request
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ctrl <= `CTRL_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i && wb_adr_i == `ADDR_CTRL && wb_sel_i[0])
        ctrl <= {28'h000_0000, wb_dat_i[3:0]};
      if (wb_req && !wb_we_i)
      begin
        case (wb_adr_i)
          `ADDR_CTRL: wb_dat_o <= ctrl;
          `ADDR_STATUS: wb_dat_o <= {26'h000_0000, !fifo_in_ready, !fifo_valid, ref_mode_o, standby_o};
          `ADDR_I_SAMPLE: wb_dat_o <= {24'h00_0000, i_latch};
          `ADDR_Q_SAMPLE: wb_dat_o <= {16'h0000, fifo_valid, 7'h00, q_latch};
          `ADDR_I_INPUT: wb_dat_o <= {16'h0000, fifo_data};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

`default_nettype wire

// >>> shared/dual_adc_defines.vh
// constants for the dual converter output multiplexer
// assumes inclusion by bare name from design files
`ifndef DUAL_ADC_DEFINES_VH
`define DUAL_ADC_DEFINES_VH
// wishbone register offsets (byte addresses)
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_I_SAMPLE 8'h08
`define ADDR_Q_SAMPLE 8'h0C
`define ADDR_I_INPUT 8'h10
`define ADDR_Q_INPUT 8'h14
// control fields
`define CTRL_FLOAT_BIT 0
`define CTRL_PICK_BIT 1
`define CTRL_LOWPWR_BIT 2
`define CTRL_CLKEN_BIT 3
`define CTRL_RESET 32'h0000_0008
// status fields
`define ST_STANDBY_BIT 0
`define ST_REFMODE_LSB 1
`define ST_FIFO_EMPTY_BIT 4
`define ST_FIFO_FULL_BIT 5
// reference modes from the strap
`define REF_1V 3'h1
`define REF_2V 3'h2
`define REF_EXT 3'h4
`define REF_PROG 3'h0
// strap codes seen on the sense input
`define STRAP_VREF 2'h0
`define STRAP_ANALOG_GROUND 2'h1
`define STRAP_ANALOG_SUPPLY 2'h2
`define STRAP_TAP 2'h3
// pipeline depth in clock periods, then sample fifo depth in entries and its address width
`define PIPE_DEPTH 3
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

// >>> tb/mux_props.sv
// port assertions for the output multiplexer
// assumes binding onto dual_adc_output_mux
`timescale 1ns/1ns
`default_nettype none
module mux_props (
  // clock, reset, bus
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // pins
  input wire logic output_float_i,
  input wire logic [1:0] reference_sense_strap_i,
  input wire logic [7:0] output_bits_oe_n_o,
  input wire logic [2:0] ref_mode_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_float; output_float_i |=> output_bits_oe_n_o == 8'hFF; endproperty
  a_float: assert property (p_float) else $error("bus not released");
  property p_whole; output_bits_oe_n_o inside {8'h00, 8'hFF}; endproperty
  a_whole: assert property (p_whole) else $error("partial enable");
  property p_ref1; reference_sense_strap_i == 2'h0 |=> ref_mode_o == 3'h1; endproperty
  a_ref1: assert property (p_ref1) else $error("not 1 V mode");
  property p_ref2; reference_sense_strap_i == 2'h1 |=> ref_mode_o == 3'h2; endproperty
  a_ref2: assert property (p_ref2) else $error("not 2 V mode");
  property p_refx; reference_sense_strap_i == 2'h2 |=> ref_mode_o == 3'h4; endproperty
  a_refx: assert property (p_refx) else $error("not external mode");
  property p_refp; ref_mode_o == 3'h0 |-> $past(reference_sense_strap_i) == 2'h3; endproperty
  a_refp: assert property (p_refp) else $error("stray divider mode");
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
endmodule
bind dual_adc_output_mux mux_props i_props (.clk_sys_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .output_float_i, .reference_sense_strap_i, .output_bits_oe_n_o, .ref_mode_o);
`default_nettype wire

// >>> tb/demux_model.sv
// receiving side: splits the shared word into two latches
// assumes pick doubles as the receive phase signal
`timescale 1ns/1ns
`default_nettype none
module demux_model (
  // from the converter
  input wire logic pick_i,
  input wire logic [7:0] bits_i,
  input wire logic [7:0] oe_n_i,
  // captured words
  output logic [7:0] i_word_o,
  output logic [7:0] q_word_o
);
  logic [7:0] bus;
  // released bus shows no stale value
  assign bus = (oe_n_i == 8'h00) ? bits_i : ~bits_i;
  always @(negedge pick_i) i_word_o <= bus;
  always @(posedge pick_i) q_word_o <= bus;
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the output multiplexer
// assumes the demux model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_sys_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, fl = 0, pk = 0, lp = 0, ack, sb;
  logic [7:0] adr = 0, il = 0, ql = 0, a, b, ob, oe, iw, qw;
  logic [1:0] st = 0;
  logic [2:0] rm;
  logic [31:0] dat = 0, rd, q, s = 32'h5283;
  int num_errors = 0, samples_checked = 0, n;
  initial forever #20 clk_sys_i = ~clk_sys_i;
  dual_adc_output_mux i_dut (.clk_sys_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack), .i_level_i(il), .q_level_i(ql),
    .output_float_i(fl), .channel_pick_i(pk), .low_power_request_i(lp), .reference_sense_strap_i(st),
    .output_bits_o(ob), .output_bits_oe_n_o(oe), .standby_o(sb), .ref_mode_o(rm));
  demux_model i_rx (.pick_i(pk), .bits_i(ob), .oe_n_i(oe), .i_word_o(iw), .q_word_o(qw));
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask
  task automatic wb(input logic w, input logic [7:0] x, input logic [31:0] d);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= x;
    dat <= d;
    for (n = 0; n < 20 && ack !== 1'b1; n++)
      tick(1);
    chk("ack", 1, ack);
    if (ack !== 1'b1)
      wrap_up;
    rd = q;
    cyc <= 0;
    stb <= 0;
    tick(1);
  endtask
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  ////////////////////////////////////////////////////////////////
  initial
  begin
    tick(2);
    rst_i <= 0;
    wb(0, 8'h00, 0);
    chk("ctrl", 32'h0000_0008, rd);
    for (int k = 0; k < 4; k++)
    begin
      st <= k[1:0];
      tick(3);
      chk("ref mode", (k == 3) ? 3'h0 : 3'h1 << k, rm);
      s = nx(s);
      a = (k < 2) ? {8{k[0]}} : s[7:0];
      b = (k < 2) ? ~a : s[15:8];
      rst_i <= 1;
      il <= a;
      ql <= b;
      pk <= 1;
      fl <= k[0];
      tick(1);
      rst_i <= 0;
      tick(6);
      chk("oe_n", {8{k[0]}}, oe);
      fl <= 0;
      il <= ~a;
      tick(5);
      chk("word i old", a, ob);
      chk("oe_n", 0, oe);
      tick(1);
      chk("word i new", {~a}, ob);
      pk <= 0;
      tick(2);
      chk("word q", b, ob);
      chk("rx i", {~a}, iw);
      pk <= 1;
      tick(1);
      chk("rx q", b, qw);
    end
    tick(20);
    wb(0, 8'h04, 0);
    chk("full", 1, rd[5]);
    wb(1, 8'h00, 0);
    lp <= 1;
    tick(3);
    chk("standby", 1, sb);
    lp <= 0;
    tick(3);
    chk("standby", 0, sb);
    repeat (16) wb(0, 8'h10, 0);
    chk("head", {~a, b}, rd[15:0]);
    wb(0, 8'h04, 0);
    chk("empty", 1, rd[4]);
    wb(1, 8'h20, 32'hFFFF_FFFF);
    wb(0, 8'h20, 0);
    chk("unmapped", 0, rd);
    wrap_up;
  end
endmodule
`default_nettype wire
